// *** hw/nv_prog_defs.vh ***
// Register map, field positions, reset values and timing for the NV programming and ECC test block.
// Assumes register indices are word indices on APB: byte address = 4 * index.
`ifndef NV_PROG_DEFS_VH
`define NV_PROG_DEFS_VH

// Register indices (APB byte address is four times these)
`define IDX_UNLOCK1_A 14'h0300
`define IDX_UNLOCK1_D 14'h0303
`define IDX_PROG_CTRL 14'h030b
`define IDX_TEST_IN_1 14'h0343
`define IDX_TEST_IN_9 14'h034b
`define IDX_TEST_SETUP 14'h034c
`define IDX_UNLOCK2_A 14'h0352
`define IDX_UNLOCK2_D 14'h0355
`define IDX_FAULT_FLAGS 14'h0360
`define IDX_FAULT_CLEAR 14'h0361
`define IDX_IRQ_STATUS 14'h0362
`define IDX_IRQ_MASK 14'h0363
`define IDX_RESULT_1 14'h0510
`define IDX_RESULT_9 14'h0518
`define IDX_PROG_STATUS 14'h0519

// Program control fields
`define CTRL_START_BIT 0
`define CTRL_PAGE_BIT 1

// Test setup fields
`define TEST_ENABLE_BIT 0
`define TEST_DIR_BIT 1
`define TEST_SRC_BIT 2
`define TEST_CHOICE_BIT 3

// Program status fields
`define STAT_DONE_BIT 0
`define STAT_FAULT_BIT 1
`define STAT_START_HIGH_BIT 2
`define STAT_START_LOW_BIT 3
`define STAT_HIGH_BIT 4
`define STAT_LOW_BIT 5
`define STAT_OVERTEMP_BIT 6
`define STAT_UNLOCK_BIT 7

// Fault flag and fault clear fields
`define FLT_SINGLE_BIT 0
`define FLT_DOUBLE_BIT 1
`define FLT_CLEAR_BIT 0

// Interrupt status and mask fields
`define IRQ_DONE_BIT 0
`define IRQ_OVERTEMP_BIT 1
`define IRQ_FAULT_BIT 2
`define IRQ_SINGLE_BIT 3
`define IRQ_DOUBLE_BIT 4

// Reset values
`define RST_BYTE 8'h00
`define RST_IRQ 5'h00

// Timing: page programming time and clock period
`define PROG_TIME_NS 100000
`define CLK_PERIOD_NS 4
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** hw/ecc_secded.v ***
// Combinational SEC-DED code over 64 data bits: extended Hamming, 7 check bits plus overall parity.
// Assumes the caller registers results; check byte is {overall parity, check[6:0]}.
`timescale 1ns/1ps
`default_nettype none

module ecc_secded (
  // Operands
  input wire [63:0] data_in,
  input wire [7:0] check_in,
  // Encoder result
  output reg [7:0] check_out,
  // Decoder results
  output reg [63:0] data_fix,
  output reg single_err,
  output reg double_err
);

  reg [71:0] enc_cw;
  reg [71:0] dec_cw;
  reg [6:0] syn;
  reg par;
  integer p;
  integer k;

  // Scatter data into non power-of-two positions, derive checks and syndrome
  always @* begin
    enc_cw = 72'h0;
    dec_cw = 72'h0;
    syn = 7'h0;
    check_out = 8'h00;
    k = 0;
    for (p = 1; p < 72; p = p + 1) begin
      if ((p & (p - 1)) != 0) begin
        enc_cw[p] = data_in[k];
        k = k + 1;
      end
    end
    for (p = 1; p < 72; p = p + 1) begin
      if (enc_cw[p]) begin
        check_out[6:0] = check_out[6:0] ^ p[6:0];
      end
    end
    check_out[7] = ^{enc_cw, check_out[6:0]};
    // Received word: stored checks sit at power-of-two positions
    dec_cw = enc_cw;
    for (k = 0; k < 7; k = k + 1) begin
      dec_cw[1 << k] = check_in[k];
    end
    for (p = 1; p < 72; p = p + 1) begin
      if (dec_cw[p]) begin
        syn = syn ^ p[6:0];
      end
    end
    par = (^dec_cw) ^ check_in[7];
    // Odd parity flip means one bit in error; even with syndrome means two
    single_err = par;
    double_err = !par && (syn != 7'h0);
    if (par && syn != 7'h0 && syn < 7'd72) begin
      dec_cw[syn] = !dec_cw[syn];
    end
    data_fix = 64'h0;
    k = 0;
    for (p = 1; p < 72; p = p + 1) begin
      if ((p & (p - 1)) != 0) begin
        data_fix[k] = dec_cw[p];
        k = k + 1;
      end
    end
  end

endmodule

`default_nettype wire

// *** hw/nv_program_ctrl_ecc_test.v ***
// NV page programming control and ECC self-test, as an APB slave with one level interrupt.
// Assumes one clock REF_CLK; temperature and supply monitors arrive asynchronously as pins.
//
// How it works
// - Page select bit picks page 1 (0) or page 2 (1); a start uses the bit as held before its own write.
// - Writing start bit 1 begins programming; start reads 0 when ready.
// - Test enable bit 1 launches the configured ECC test; 0 is normal operation.
// - Direction bit: 0 runs decoder test, 1 runs encoder test.
// - Decoder choice 0 tests single-error, 1 double-error, each setting its flag.
// - Encoder test ignores the decoder choice bit.
// - Single and double flags hold until fault clear; neither test clears the other.
// - Source bit: 0 internal operands, 1 host-written input bytes.
// - Manual mode lets the host supply operands for latent multi-point fault tests.
// - Nine input bytes are RW, reset zero, used only in manual mode.
// - Manual encoder uses inputs 8..1; manual decoder uses inputs 9..1.
// - Results go to read-only bytes: decoder 8..1, encoder 9..1.
// - Hot die refuses programming start and sets over-temperature error.
// - Writing start 1 clears the programming error status bits.
// - Done bit reads 1 after the page finishes, else 0.
`timescale 1ns/1ps
`default_nettype none
`include "nv_prog_defs.vh"

module nv_program_ctrl_ecc_test #(
  parameter PROG_CYCLES = `PROG_CYCLES,
  parameter [31:0] UNLOCK1_CODE = 32'h1234_5678, // Arbitrary value
  parameter [31:0] UNLOCK2_CODE = 32'h9abc_def0, // Arbitrary value
  parameter [63:0] AUTO_DATA = 64'h0f1e_2d3c_4b5a_6978
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [15:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // Asynchronous monitors
  input wire DIE_TEMP_HOT,
  input wire PROG_SUPPLY_LOW,
  input wire PROG_SUPPLY_HIGH,
  // NV array programming drive
  output wire NV_PROG_ACTIVE,
  output wire NV_PROG_PAGE,
  // Interrupt
  output wire IRQ
);

  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;

  // Unlock tracker step: state is {ok, next lane, collected bytes}
  function [26:0] unlock_step;
    input [26:0] st;
    input [1:0] lane;
    input [7:0] wbyte;
    input [31:0] code;
    begin
      if (lane == 2'd0) begin
        unlock_step = {1'b0, 2'd1, 16'h0000, wbyte};
      end else if (lane != st[25:24]) begin
        unlock_step = {1'b0, 2'd0, 24'h00_0000}; // Out of order entry restarts
      end else if (lane == 2'd3) begin
        unlock_step = {({st[23:0], wbyte} == code), 2'd0, 24'h00_0000};
      end else begin
        unlock_step = {1'b0, lane + 2'd1, st[15:0], wbyte};
      end
    end
  endfunction

  // Index range test
  function in_range;
    input [13:0] idx;
    input [13:0] lo;
    input [13:0] hi;
    begin
      in_range = (idx >= lo) && (idx <= hi);
    end
  endfunction

  // Bus decode
  wire [13:0] idx = PADDR[15:2];
  wire aligned = (PADDR[1:0] == 2'b00);
  wire setup = PSEL && !PENABLE;
  wire wr = PSEL && PENABLE && PWRITE;
  wire [7:0] wb = PWDATA[7:0];
  wire hit_unl1 = in_range(idx, `IDX_UNLOCK1_A, `IDX_UNLOCK1_D);
  wire hit_unl2 = in_range(idx, `IDX_UNLOCK2_A, `IDX_UNLOCK2_D);
  wire hit_in = in_range(idx, `IDX_TEST_IN_1, `IDX_TEST_IN_9);
  wire hit_out = in_range(idx, `IDX_RESULT_1, `IDX_RESULT_9);
  wire hit_ctrl = (idx == `IDX_PROG_CTRL);
  reg mapped;
  always @* begin
    mapped = aligned && (hit_unl1 || hit_unl2 || hit_in || hit_out || hit_ctrl ||
      idx == `IDX_TEST_SETUP || idx == `IDX_PROG_STATUS || idx == `IDX_FAULT_FLAGS ||
      idx == `IDX_FAULT_CLEAR || idx == `IDX_IRQ_STATUS || idx == `IDX_IRQ_MASK);
  end
  wire wr_ok = wr && mapped;

  // Zero wait state slave; unmapped or misaligned addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Monitor synchronisers, second stage only is ever read
  reg [2:0] mon_s1_q;
  reg [2:0] mon_s2_q;
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      mon_s1_q <= 3'b000;
      mon_s2_q <= 3'b000;
    end else begin
      mon_s1_q <= {PROG_SUPPLY_HIGH, PROG_SUPPLY_LOW, DIE_TEMP_HOT};
      mon_s2_q <= mon_s1_q;
    end
  end
  wire hot = mon_s2_q[0];
  wire sup_low = mon_s2_q[1];
  wire sup_high = mon_s2_q[2];

  // Software registers
  reg page_q;
  reg [3:0] setup_q;
  reg [7:0] tin_q [1:9];
  reg [4:0] irq_mask_q;
  reg [26:0] unl1_q;
  reg [26:0] unl2_q;
  reg unlock_q;
  integer i;

  wire start_wr = wr_ok && hit_ctrl && wb[`CTRL_START_BIT];
  wire unrelated_wr = wr_ok && !hit_unl1 && !hit_unl2 && !hit_ctrl;

  // Control, operand and unlock registers
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      page_q <= 1'b0;
      setup_q <= 4'h0;
      irq_mask_q <= `RST_IRQ;
      unl1_q <= 27'h0;
      unl2_q <= 27'h0;
      unlock_q <= 1'b0;
      for (i = 1; i <= 9; i = i + 1) begin
        tin_q[i] <= `RST_BYTE;
      end
    end else begin
      if (wr_ok && hit_ctrl) begin
        page_q <= wb[`CTRL_PAGE_BIT];
      end
      if (wr_ok && idx == `IDX_TEST_SETUP) begin
        setup_q <= wb[3:0];
      end
      if (wr_ok && idx == `IDX_IRQ_MASK) begin
        irq_mask_q <= wb[4:0];
      end
      if (wr_ok && hit_in) begin
        tin_q[idx - `IDX_TEST_IN_1 + 14'd1] <= wb;
      end
      // Codes enter byte by byte, A first, D last
      if (wr_ok && hit_unl1) begin
        unl1_q <= unlock_step(unl1_q, idx[1:0], wb, UNLOCK1_CODE);
      end
      if (wr_ok && hit_unl2) begin
        unl2_q <= unlock_step(unl2_q, idx[1:0] - 2'd2, wb, UNLOCK2_CODE);
      end
      // Unlock only after both codes; dropped on start or stray write
      if (start_wr || unrelated_wr) begin
        unlock_q <= 1'b0;
        unl1_q <= 27'h0;
        unl2_q <= 27'h0;
      end else begin
        unlock_q <= unl1_q[26] && unl2_q[26];
      end
    end
  end

  // Programming sequencer
  reg [1:0] state_q;
  reg [15:0] cnt_q;
  reg act_page_q;
  reg done_q;
  reg fault_q;
  reg start_low_q;
  reg start_high_q;
  reg low_q;
  reg high_q;
  reg overtemp_q;
  wire prog_ok = !hot && unlock_q && !sup_low && !sup_high;
  wire run_end = (state_q == ST_RUN) && (cnt_q == 16'd1);
  wire run_abort = (state_q == ST_RUN) && (sup_low || sup_high);

  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      act_page_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      start_low_q <= 1'b0;
      start_high_q <= 1'b0;
      low_q <= 1'b0;
      high_q <= 1'b0;
      overtemp_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // A start while busy is ignored; start writes only act here
          if (start_wr) begin
            done_q <= 1'b0;
            low_q <= 1'b0;
            high_q <= 1'b0;
            start_low_q <= sup_low;
            start_high_q <= sup_high;
            overtemp_q <= hot;
            fault_q <= !unlock_q;
            if (prog_ok) begin
              state_q <= ST_RUN;
              cnt_q <= PROG_CYCLES[15:0];
              act_page_q <= page_q;
            end
          end
        end
        ST_RUN: begin
          if (run_abort) begin
            low_q <= sup_low;
            high_q <= sup_high;
            fault_q <= 1'b1;
            state_q <= ST_IDLE;
          end else if (run_end) begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'd1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign NV_PROG_ACTIVE = (state_q == ST_RUN);
  assign NV_PROG_PAGE = act_page_q;

  // ECC test operand selection
  reg test_go_q;
  wire dir_enc = setup_q[`TEST_DIR_BIT];
  wire manual = setup_q[`TEST_SRC_BIT];
  wire choice_dbl = setup_q[`TEST_CHOICE_BIT];
  reg [63:0] man_data;
  always @* begin
    for (i = 1; i <= 8; i = i + 1) begin
      man_data[i * 8 - 1 -: 8] = tin_q[i];
    end
  end
  wire [7:0] auto_chk;
  wire [63:0] op_data = manual ? man_data : AUTO_DATA;
  // Auto decoder test corrupts one bit (single) or two bits (double) of stored data
  wire [63:0] inj = choice_dbl ? 64'h0000_0000_0000_0003 : 64'h0000_0000_0000_0001;
  wire [63:0] dec_data = manual ? man_data : (AUTO_DATA ^ inj);
  wire [7:0] dec_chk = manual ? tin_q[9] : auto_chk;
  wire [63:0] fix_data;
  wire single_err;
  wire double_err;
  wire [7:0] enc_chk;

  // Encoder for the auto reference checks
  ecc_secded u_ref (
    .data_in(AUTO_DATA),
    .check_in(8'h00),
    .check_out(auto_chk),
    .data_fix(),
    .single_err(),
    .double_err()
  );

  // Unit under test: encodes op_data, decodes dec_data with dec_chk
  ecc_secded u_dut (
    .data_in(dir_enc ? op_data : dec_data),
    .check_in(dec_chk),
    .check_out(enc_chk),
    .data_fix(fix_data),
    .single_err(single_err),
    .double_err(double_err)
  );

  // Test launches one cycle after a setup write with enable set
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      test_go_q <= 1'b0;
    end else begin
      test_go_q <= wr_ok && (idx == `IDX_TEST_SETUP) && wb[`TEST_ENABLE_BIT];
    end
  end

  // Result bytes and sticky decoder flags
  reg [7:0] tout_q [1:9];
  reg flag_single_q;
  reg flag_double_q;
  wire set_single = test_go_q && !dir_enc && !choice_dbl && single_err;
  wire set_double = test_go_q && !dir_enc && choice_dbl && double_err;
  wire flt_clr = wr_ok && (idx == `IDX_FAULT_CLEAR) && wb[`FLT_CLEAR_BIT];

  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      flag_single_q <= 1'b0;
      flag_double_q <= 1'b0;
      for (i = 1; i <= 9; i = i + 1) begin
        tout_q[i] <= `RST_BYTE;
      end
    end else begin
      // Each flag has its own set and only the clear bit drops it; set wins
      flag_single_q <= set_single || (flag_single_q && !flt_clr);
      flag_double_q <= set_double || (flag_double_q && !flt_clr);
      if (test_go_q) begin
        for (i = 1; i <= 8; i = i + 1) begin
          tout_q[i] <= dir_enc ? op_data[i * 8 - 1 -: 8] : fix_data[i * 8 - 1 -: 8];
        end
        tout_q[9] <= dir_enc ? enc_chk : 8'h00;
      end
    end
  end

  // Interrupt events: sticky, write one to clear, set wins over clear
  reg [4:0] irq_st_q;
  wire [4:0] irq_ev;
  assign irq_ev[`IRQ_DONE_BIT] = run_end && !run_abort;
  assign irq_ev[`IRQ_OVERTEMP_BIT] = (state_q == ST_IDLE) && start_wr && hot;
  assign irq_ev[`IRQ_FAULT_BIT] = ((state_q == ST_IDLE) && start_wr && !unlock_q) || run_abort;
  assign irq_ev[`IRQ_SINGLE_BIT] = set_single;
  assign irq_ev[`IRQ_DOUBLE_BIT] = set_double;
  wire [4:0] irq_w1c = (wr_ok && idx == `IDX_IRQ_STATUS) ? wb[4:0] : 5'h00;

  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      irq_st_q <= `RST_IRQ;
    end else begin
      irq_st_q <= irq_ev | (irq_st_q & ~irq_w1c);
    end
  end

  assign IRQ = |(irq_st_q & irq_mask_q);

  // Read mux; unlock bytes and fault clear always read zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (hit_in) begin
      rd_byte = tin_q[idx - `IDX_TEST_IN_1 + 14'd1];
    end else if (hit_out) begin
      rd_byte = tout_q[idx - `IDX_RESULT_1 + 14'd1];
    end else begin
      case (idx)
        `IDX_PROG_CTRL: rd_byte = {6'h00, page_q, NV_PROG_ACTIVE};
        `IDX_TEST_SETUP: rd_byte = {4'h0, setup_q};
        `IDX_PROG_STATUS: rd_byte = {unlock_q, overtemp_q, low_q, high_q,
          start_low_q, start_high_q, fault_q, done_q};
        `IDX_FAULT_FLAGS: rd_byte = {6'h00, flag_double_q, flag_single_q};
        `IDX_IRQ_STATUS: rd_byte = {3'h0, irq_st_q};
        `IDX_IRQ_MASK: rd_byte = {3'h0, irq_mask_q};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Read data captured in the setup cycle so it comes from a flip-flop
  reg [7:0] prdata_q;
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      prdata_q <= 8'h00;
    end else if (setup) begin
      prdata_q <= (mapped && !PWRITE) ? rd_byte : 8'h00;
    end
  end

  assign PRDATA = {24'h00_0000, prdata_q};

endmodule

`default_nettype wire

// *** verif/nv_program_ctrl_ecc_test_assertions.sv ***
// Checker for the NV programming and ECC test block, on its top ports only.
// Assumes zero-wait APB and the shortened programming length handed on by the bind.
`timescale 1ns/1ps
`default_nettype none

module nv_prog_checker #(
  parameter PROG_CYCLES = 8
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET,
  // APB
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [15:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PSLVERR,
  // Monitor and array drive
  input wire DIE_TEMP_HOT,
  input wire NV_PROG_ACTIVE,
  input wire NV_PROG_PAGE,
  input wire IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  // Write access and start request decode
  wire wr_acc = PSEL && PENABLE && PWRITE;
  wire start_w = wr_acc && PADDR == 16'h0c2c && PWDATA[0];
  // Length of the current run; wide enough for any shortened count
  reg [15:0] run_q;

  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) run_q <= 16'h0000;
    else run_q <= NV_PROG_ACTIVE ? run_q + 16'h0001 : 16'h0000;
  end

  // Hot must be held three samples, or the synchroniser may still show cool
  sequence hot_start;
    start_w && !NV_PROG_ACTIVE && DIE_TEMP_HOT && $past(DIE_TEMP_HOT) && $past(DIE_TEMP_HOT, 2);
  endsequence
  sequence launch;
    $rose(NV_PROG_ACTIVE);
  endsequence

  read_upper_zero_a: assert property (PRDATA[31:8] == 24'h00_0000) else $error("PRDATA upper bits set");
  err_in_access_a: assert property (PSLVERR |-> PSEL && PENABLE) else $error("PSLVERR outside access");
  unmapped_err_a: assert property (PSEL && PENABLE && PADDR == 16'h0004 |-> PSLVERR)
    else $error("Unmapped access not refused");
  hot_refuse_a: assert property (hot_start |=> !NV_PROG_ACTIVE) else $error("Programming started while hot");
  launch_cause_a: assert property (launch |-> $past(start_w) && !$past(DIE_TEMP_HOT, 3))
    else $error("Programming began without a cool start write");
  page_latch_a: assert property (launch |-> NV_PROG_PAGE == $past(PWDATA[1])) else $error("Page not latched");
  page_hold_a: assert property (NV_PROG_ACTIVE && $past(NV_PROG_ACTIVE) |-> $stable(NV_PROG_PAGE))
    else $error("Page changed during run");
  run_bound_a: assert property (run_q <= PROG_CYCLES) else $error("Run too long");
  run_full_a: assert property ($fell(NV_PROG_ACTIVE) |-> run_q == PROG_CYCLES) else $error("Run cut short");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3)
    || $past(NV_PROG_ACTIVE)) else $error("Interrupt without an event");
  launch_c: cover property (launch);
endmodule

bind nv_program_ctrl_ecc_test nv_prog_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .DIE_TEMP_HOT(DIE_TEMP_HOT),
  .NV_PROG_ACTIVE(NV_PROG_ACTIVE), .NV_PROG_PAGE(NV_PROG_PAGE), .IRQ(IRQ));
`default_nettype wire

// *** verif/nv_program_ctrl_ecc_test_tb.sv ***
// Self-checking bench for the NV programming and ECC test block over APB.
// Assumes the register map header is on the include path; supply monitors stay quiet.
`timescale 1ns/1ps
`default_nettype none
`include "nv_prog_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module nv_program_ctrl_ecc_test_tb;
  localparam [31:0] U1 = 32'h1234_5678; // Arbitrary value
  localparam [31:0] U2 = 32'h9abc_def0; // Arbitrary value
  localparam [63:0] AUTO = 64'h0f1e_2d3c_4b5a_6978;
  reg REF_CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, DIE_TEMP_HOT = 0;
  reg [15:0] PADDR = 16'h0000;
  reg [31:0] PWDATA = 32'h0000_0000;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, NV_PROG_ACTIVE, NV_PROG_PAGE, IRQ;
  integer fail_count = 0, cmp_count = 0, i, t, k;
  reg [31:0] rd;
  reg err, pg;
  reg [63:0] d;

  nv_program_ctrl_ecc_test #(.PROG_CYCLES(8), .UNLOCK1_CODE(U1), .UNLOCK2_CODE(U2), .AUTO_DATA(AUTO)) u_dut (
    .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DIE_TEMP_HOT(DIE_TEMP_HOT),
    .PROG_SUPPLY_LOW(1'b0), .PROG_SUPPLY_HIGH(1'b0), .NV_PROG_ACTIVE(NV_PROG_ACTIVE),
    .NV_PROG_PAGE(NV_PROG_PAGE), .IRQ(IRQ));

  // 250 MHz clock
  initial forever #2 REF_CLK = ~REF_CLK;

  task end_of_test;
    begin
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task timeout;
    begin
      fail_count++;
      end_of_test;
    end
  endtask

  // One APB transfer; the request holds until PREADY is seen high
  task apb(input w, input [13:0] a, input [7:0] v);
    integer n;
    begin
      @(posedge REF_CLK);
      PSEL <= 1;
      PENABLE <= 0;
      PWRITE <= w;
      PADDR <= {a, 2'b00};
      PWDATA <= {24'h00_0000, v};
      @(posedge REF_CLK);
      PENABLE <= 1;
      @(posedge REF_CLK);
      for (n = 0; PREADY !== 1'b1; n++) begin
        if (n == 50) timeout;
        @(posedge REF_CLK);
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
    end
  endtask

  task wr(input [13:0] a, input [7:0] v);
    apb(1, a, v);
  endtask

  task rdc(input [13:0] a, input [7:0] e);
    begin
      apb(0, a, 8'h00);
      `CHK($sformatf("reg %h", a), {24'h00_0000, e}, rd)
    end
  endtask

  // Expected check byte: extended Hamming, data in non power of two positions
  function [7:0] enc(input [63:0] dd);
    reg [71:0] w;
    integer p, q;
    begin
      w = 72'h0;
      q = 0;
      enc = 8'h00;
      for (p = 1; p < 72; p++) if ((p & (p - 1)) != 0) begin
        w[p] = dd[q];
        q++;
      end
      for (p = 1; p < 72; p++) if (w[p]) enc[6:0] = enc[6:0] ^ p[6:0];
      enc[7] = ^w ^ ^enc[6:0];
    end
  endfunction

  task ops(input [63:0] dd, input [7:0] cc);
    begin
      for (i = 0; i < 8; i++) wr(`IDX_TEST_IN_1 + i[13:0], dd[8*i +: 8]);
      wr(`IDX_TEST_IN_9, cc);
    end
  endtask

  // Launch a test, then let the results settle before reading
  task run(input [7:0] s);
    begin
      wr(`IDX_TEST_SETUP, s);
      repeat (2) @(posedge REF_CLK);
    end
  endtask

  task res(input [63:0] dd, input [7:0] cc);
    begin
      for (i = 0; i < 8; i++) rdc(`IDX_RESULT_1 + i[13:0], dd[8*i +: 8]);
      rdc(`IDX_RESULT_9, cc);
    end
  endtask

  // Both codes, byte A first, then time for the unlock bit to land
  task unl;
    begin
      for (i = 0; i < 4; i++) wr(`IDX_UNLOCK1_A + i[13:0], U1[31 - 8*i -: 8]);
      for (i = 0; i < 4; i++) wr(`IDX_UNLOCK2_A + i[13:0], U2[31 - 8*i -: 8]);
      repeat (2) @(posedge REF_CLK);
    end
  endtask

  task wait_active(input v);
    integer n;
    for (n = 0; NV_PROG_ACTIVE !== v; n++) begin
      if (n == 100) timeout;
      @(negedge REF_CLK);
    end
  endtask

  initial begin
    t = $urandom(32'h6e45_02bc);
    repeat (3) @(posedge REF_CLK);
    RESET <= 0;
    for (i = 0; i < 9; i++) rdc(`IDX_TEST_IN_1 + i[13:0], 8'h00);
    for (i = 0; i < 9; i++) rdc(`IDX_RESULT_1 + i[13:0], 8'h00);
    rdc(`IDX_PROG_STATUS, 8'h00);
    rdc(`IDX_TEST_SETUP, 8'h00);
    wr(`IDX_UNLOCK1_A, 8'h5a);
    rdc(`IDX_UNLOCK1_A, 8'h00);
    apb(0, 14'h0001, 8'h00);
    `CHK("unmapped error", 1'b1, err)
    wr(`IDX_RESULT_1, 8'ha5);
    rdc(`IDX_RESULT_1, 8'h00);
    d = {$urandom, $urandom};
    ops(d, d[7:0] ^ 8'hff);
    for (i = 0; i < 8; i++) rdc(`IDX_TEST_IN_1 + i[13:0], d[8*i +: 8]);
    // Start while locked: refused and flagged
    wr(`IDX_IRQ_MASK, 8'h1f);
    wr(`IDX_PROG_CTRL, 8'h01);
    repeat (3) @(negedge REF_CLK);
    `CHK("locked active", 1'b0, NV_PROG_ACTIVE)
    rdc(`IDX_PROG_STATUS, 8'h02);
    `CHK("fault irq", 1'b1, IRQ)
    wr(`IDX_IRQ_STATUS, 8'h04);
    @(negedge REF_CLK);
    `CHK("irq cleared", 1'b0, IRQ)
    unl;
    rdc(`IDX_PROG_STATUS, 8'h82);
    wr(`IDX_TEST_IN_1, 8'h00);
    rdc(`IDX_PROG_STATUS, 8'h02);
    // Hot die: start refused, over-temperature reported
    DIE_TEMP_HOT <= 1;
    unl;
    wr(`IDX_PROG_CTRL, 8'h01);
    repeat (3) @(negedge REF_CLK);
    `CHK("hot active", 1'b0, NV_PROG_ACTIVE)
    rdc(`IDX_PROG_STATUS, 8'h40);
    wr(`IDX_IRQ_STATUS, 8'h02);
    @(posedge REF_CLK);
    DIE_TEMP_HOT <= 0;
    unl;
    pg = $urandom;
    wr(`IDX_PROG_CTRL, {6'h00, pg, 1'b1});
    wait_active(1);
    `CHK("page", pg, NV_PROG_PAGE)
    rdc(`IDX_PROG_CTRL, {6'h00, pg, 1'b1});
    wait_active(0);
    repeat (2) @(posedge REF_CLK);
    rdc(`IDX_PROG_STATUS, 8'h01);
    rdc(`IDX_PROG_CTRL, {6'h00, pg, 1'b0});
    wr(`IDX_IRQ_MASK, 8'h00);
    @(negedge REF_CLK);
    `CHK("masked irq", 1'b0, IRQ)
    wr(`IDX_IRQ_MASK, 8'h1f);
    @(negedge REF_CLK);
    `CHK("done irq", 1'b1, IRQ)
    wr(`IDX_IRQ_STATUS, 8'h01);
    // ECC: manual encoder with choice set, then manual single error decode
    for (t = 0; t < 3; t++) begin
      d = {$urandom, $urandom};
      k = $urandom % 64;
      ops(d, $urandom);
      run(8'h0f);
      res(d, enc(d));
      // Single flag from the previous pass survives the encoder run
      rdc(`IDX_FAULT_FLAGS, (t == 0) ? 8'h00 : 8'h01);
      ops(d ^ (64'h1 << k), enc(d));
      run(8'h05);
      res(d, 8'h00);
      rdc(`IDX_FAULT_FLAGS, 8'h01);
    end
    k = $urandom % 63;
    ops(d ^ (64'h3 << k), enc(d));
    run(8'h0d);
    rdc(`IDX_FAULT_FLAGS, 8'h03);
    run(8'h01);
    res(AUTO, 8'h00);
    run(8'h03);
    res(AUTO, enc(AUTO));
    ops(~AUTO, 8'h00);
    run(8'h00);
    res(AUTO, enc(AUTO));
    rdc(`IDX_FAULT_FLAGS, 8'h03);
    wr(`IDX_FAULT_CLEAR, 8'h01);
    rdc(`IDX_FAULT_FLAGS, 8'h00);
    wr(`IDX_IRQ_STATUS, 8'h18);
    @(negedge REF_CLK);
    `CHK("final irq", 1'b0, IRQ)
    end_of_test;
  end
endmodule
`default_nettype wire
